// file: verilog/mux_amp_scan_regs.svh
// Register map, field positions, reset values and timing counts of the scan control.
// Assumes inclusion by bare name from the design file; holds definitions only.
//
// Functional notes
// - Each read of addresses 0 to 7, and each write except to 0 and 2, is decoded to exactly one register by its address; addresses 8 to 15 reach none.
// - A read-only identification register returns a fixed code for this module type.
// - Configuration selects scanning mode and rear connector output connection.
// - Each of 32 channels has its own gain bit: unity or one hundred.
// - Channel register names single channel or the start channel of a scan.
// - Status shows whether channels have settled after a gain change.
// - A register gives the controller access to the calibration memory.
// - Logic sequences scanning, sensor selection and gain application automatically.
// - Thirty-two channels and cold-junction sensor share one mux, one source at once.
`ifndef MUX_AMP_SCAN_REGS_SVH
`define MUX_AMP_SCAN_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_IDENT 4'h0
`define REG_CONFIG 4'h1
`define REG_STATUS 4'h2
`define REG_CALMEM 4'h3
`define REG_GAIN 4'h4
`define REG_CHANNEL 4'h5
`define REG_IRQ_STAT 4'h6
`define REG_IRQ_MASK 4'h7

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CFG_SCAN_BIT 0
`define CFG_REAR_BIT 1
`define ST_SETTLED_BIT 0
`define ST_SCANNING_BIT 1
`define IRQ_SETTLED_BIT 0
`define IRQ_WRAP_BIT 1
`define CALMEM_DATA_MSB 7
`define CALMEM_SDA_BIT 8
`define CALMEM_SCL_BIT 9
`define CALMEM_CS_BIT 10
`define CFG_RESET 2'h0
`define GAIN_RESET 32'h0000_0000
`define CHAN_RESET 6'h00
`define CJ_SOURCE 6'h20

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define SETTLE_TIME_S 3
// Cycles per second are worked out first so the product stays inside a 32-bit int.
`define SETTLE_CYCLES (`SETTLE_TIME_S * (1000000000 / `CLK_PERIOD_NS))

`endif

// file: verilog/mux_amp_scan_pkg.sv
// Types shared by the scan control logic.
// Assumes nothing beyond a SystemVerilog compiler.
package mux_amp_scan_pkg;

   // Register bus request from the controlling module.
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

   // Calibration memory serial pins.
   typedef struct packed {
      logic cs;
      logic scl;
      logic sda_o;
      logic sda_oe;
   } calmem_s;

   // Settle state machine, Gray coded.
   typedef enum logic [1:0] {
      ST_SETTLED = 2'b00,
      ST_WAITING = 2'b01
   } settle_e;

endpackage

// file: verilog/mux_amp_scan_control.sv
// Digital control of a 32-channel multiplexing amplifier: registers, mux steering, settling.
// Assumes a single 100 MHz clock, synchronous bus inputs and one-cycle strobes.
//
// The implementer's own choices: strobed register access and the register addresses.
`include "mux_amp_scan_regs.svh"

module mux_amp_scan_control #(
   parameter logic [7:0] IDENT_CODE = 8'h5A, // Arbitrary identification value.
   parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rstn_i,
   // Register port.
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Scan advance strobe from the controller.
   input wire logic advance_i,
   // Multiplexer and amplifier controls.
   output logic [5:0] mux_sel_o,
   output logic [31:0] gain_hi_o,
   output logic rear_connect_o,
   // Calibration memory pins.
   output logic calmem_cs_o,
   output logic calmem_scl_o,
   output logic calmem_sda_o,
   output logic calmem_sda_oe_o,
   input wire logic calmem_sda_i,
   // Interrupt.
   output logic irq_o
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   mux_amp_scan_pkg::bus_req_s req;
   mux_amp_scan_pkg::calmem_s cal_q, cal_d;
   mux_amp_scan_pkg::settle_e settle_q, settle_d;
   logic [1:0] cfg_q, cfg_d;
   logic [31:0] gain_q, gain_d;
   logic [5:0] chan_q, chan_d;
   logic [5:0] mux_q, mux_d;
   logic [31:0] cnt_q, cnt_d;
   logic [1:0] irq_stat_q, irq_stat_d;
   logic [1:0] irq_mask_q, irq_mask_d;
   logic [31:0] rdata_q, rdata_d;
   logic irq_q, irq_d;
   logic sda_in_q;
   logic gain_change;
   logic settle_evt;
   logic wrap_evt;

   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // -------------------------------------------------------------------------
   // Register writes and mux steering
   // -------------------------------------------------------------------------
   // Writes land in the register that the address names and no other.
   always_comb begin
      cfg_d = cfg_q;
      gain_d = gain_q;
      chan_d = chan_q;
      cal_d = cal_q;
      irq_mask_d = irq_mask_q;
      mux_d = mux_q;
      wrap_evt = 1'b0;
      if (req.wr) begin
         case (req.addr)
            `REG_CONFIG: cfg_d = req.wdata[1:0];
            `REG_GAIN: gain_d = req.wdata;
            `REG_CHANNEL: chan_d = req.wdata[5:0];
            `REG_CALMEM: begin
               cal_d.sda_o = req.wdata[`CALMEM_SDA_BIT];
               cal_d.scl = req.wdata[`CALMEM_SCL_BIT];
               cal_d.cs = req.wdata[`CALMEM_CS_BIT];
               cal_d.sda_oe = ~req.wdata[`CALMEM_SDA_BIT];
            end
            `REG_IRQ_MASK: irq_mask_d = req.wdata[1:0];
            default: ;
         endcase
      end
      if (chan_d > `CJ_SOURCE) begin
         chan_d = `CJ_SOURCE; // Out-of-range channel clamps to the sensor source.
      end
      // Channel write reloads the mux; scan advances wrap after the sensor.
      if (req.wr && req.addr == `REG_CHANNEL) begin
         mux_d = chan_d;
      end else if (cfg_q[`CFG_SCAN_BIT] && advance_i) begin
         if (mux_q == `CJ_SOURCE) begin
            mux_d = chan_q;
            wrap_evt = 1'b1;
         end else begin
            mux_d = mux_q + 6'h01;
         end
      end
   end

   // Register the control state.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cfg_q <= `CFG_RESET;
         gain_q <= `GAIN_RESET;
         chan_q <= `CHAN_RESET;
         mux_q <= `CHAN_RESET;
         cal_q <= '0;
         irq_mask_q <= 2'h0;
      end else begin
         cfg_q <= cfg_d;
         gain_q <= gain_d;
         chan_q <= chan_d;
         mux_q <= mux_d;
         cal_q <= cal_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   // -------------------------------------------------------------------------
   // Settling timer
   // -------------------------------------------------------------------------
   // Only a write that alters a gain bit restarts the wait, so rewrites are harmless.
   assign gain_change = req.wr && req.addr == `REG_GAIN && req.wdata != gain_q;

   always_comb begin
      settle_d = settle_q;
      cnt_d = cnt_q;
      settle_evt = 1'b0;
      case (settle_q)
         mux_amp_scan_pkg::ST_SETTLED: begin
            if (gain_change) begin
               settle_d = mux_amp_scan_pkg::ST_WAITING;
               cnt_d = '0;
            end
         end
         mux_amp_scan_pkg::ST_WAITING: begin
            if (gain_change) begin
               cnt_d = '0;
            end else if (cnt_q == 32'(SETTLE_CYCLES - 1)) begin
               settle_d = mux_amp_scan_pkg::ST_SETTLED;
               settle_evt = 1'b1;
            end else begin
               cnt_d = cnt_q + 32'h1;
            end
         end
         default: settle_d = mux_amp_scan_pkg::ST_SETTLED;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         settle_q <= mux_amp_scan_pkg::ST_SETTLED;
         cnt_q <= 32'h0;
      end else begin
         settle_q <= settle_d;
         cnt_q <= cnt_d;
      end
   end

   // -------------------------------------------------------------------------
   // Settle reference for the checks
   // -------------------------------------------------------------------------
   // A second count, kept apart from the timer, so the settle check is not the timer itself.
   logic [31:0] quiet_q, quiet_d;

   always_comb begin
      quiet_d = quiet_q;
      if (gain_change) begin
         quiet_d = 32'h0;
      end else if (quiet_q != 32'(SETTLE_CYCLES)) begin
         quiet_d = quiet_q + 32'h1; // Saturates at the settling interval.
      end
   end

   // Register the reference count; reset counts as already settled.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         quiet_q <= 32'(SETTLE_CYCLES);
      end else begin
         quiet_q <= quiet_d;
      end
   end

   // -------------------------------------------------------------------------
   // Interrupts and read data
   // -------------------------------------------------------------------------
   // Events win over a write-one-to-clear in the same cycle.
   always_comb begin
      irq_stat_d = irq_stat_q;
      if (req.wr && req.addr == `REG_IRQ_STAT) begin
         irq_stat_d = irq_stat_q & ~req.wdata[1:0];
      end
      if (settle_evt) begin
         irq_stat_d[`IRQ_SETTLED_BIT] = 1'b1;
      end
      if (wrap_evt) begin
         irq_stat_d[`IRQ_WRAP_BIT] = 1'b1;
      end
      irq_d = |(irq_stat_d & irq_mask_d);
      rdata_d = 32'h0;
      if (req.rd) begin
         case (req.addr)
            `REG_IDENT: rdata_d = {24'h0, IDENT_CODE};
            `REG_CONFIG: rdata_d = {30'h0, cfg_q};
            `REG_STATUS: rdata_d = {30'h0, cfg_q[`CFG_SCAN_BIT],
               settle_q == mux_amp_scan_pkg::ST_SETTLED};
            `REG_CALMEM: rdata_d = {21'h0, cal_q.cs, cal_q.scl, cal_q.sda_o,
               7'h0, sda_in_q};
            `REG_GAIN: rdata_d = gain_q;
            `REG_CHANNEL: rdata_d = {26'h0, chan_q};
            `REG_IRQ_STAT: rdata_d = {30'h0, irq_stat_q};
            `REG_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
            default: rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         irq_stat_q <= 2'h0;
         irq_q <= 1'b0;
         rdata_q <= 32'h0;
         sda_in_q <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
         sda_in_q <= calmem_sda_i;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   // Every output is a flip-flop; gain bits feed the amplifiers directly.
   assign rdata_o = rdata_q;
   assign mux_sel_o = mux_q;
   assign gain_hi_o = gain_q;
   assign rear_connect_o = cfg_q[`CFG_REAR_BIT];
   assign calmem_cs_o = cal_q.cs;
   assign calmem_scl_o = cal_q.scl;
   assign calmem_sda_o = cal_q.sda_o;
   assign calmem_sda_oe_o = cal_q.sda_oe;
   assign irq_o = irq_q;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   ident_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == `REG_IDENT |=> rdata_o == {24'h0, IDENT_CODE})
      else $error("identification read wrong");
   gain_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `REG_GAIN |=> gain_hi_o == $past(wdata_i))
      else $error("gain write not applied");
   chan_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `REG_CHANNEL && wdata_i[5:0] <= 6'h20
      |=> mux_sel_o == $past(wdata_i[5:0]))
      else $error("channel write not routed");
   mux_range_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      mux_sel_o <= 6'h20)
      else $error("mux select out of range");
   scan_step_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_q[0] && advance_i && !wr_i && mux_sel_o < 6'h20
      |=> mux_sel_o == $past(mux_sel_o) + 6'h01)
      else $error("scan did not advance");
   single_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !cfg_q[0] && !wr_i |=> $stable(mux_sel_o))
      else $error("mux moved outside scan");
   settle_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      gain_change |=> settle_q == mux_amp_scan_pkg::ST_WAITING)
      else $error("gain change kept settled");
   status_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == `REG_STATUS
      |=> rdata_o[0] == ($past(settle_q) == mux_amp_scan_pkg::ST_SETTLED))
      else $error("status read wrong");
   rear_cfg_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `REG_CONFIG |=> rear_connect_o == $past(wdata_i[1]))
      else $error("rear connection not set");
   cal_pins_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `REG_CALMEM |=> calmem_scl_o == $past(wdata_i[9]))
      else $error("calibration clock not driven");
   decode_one_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i != `REG_GAIN |=> $stable(gain_hi_o))
      else $error("write reached wrong register");
   // Settling against the reference count, scan wrap, interrupt flags, idle read data, channel clamp, data drive and rear hold.
   settle_track_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (settle_q == mux_amp_scan_pkg::ST_SETTLED) == (quiet_q == 32'(SETTLE_CYCLES)))
      else $error("settled flag disagrees with quiet time");
   scan_wrap_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_q[0] && advance_i && !wr_i && mux_sel_o == 6'h20 |=> mux_sel_o == $past(chan_q))
      else $error("scan did not wrap to start");
   wrap_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_q[0] && advance_i && !wr_i && mux_sel_o == 6'h20 |=> irq_stat_q[1])
      else $error("scan wrap not flagged");
   settle_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      settle_evt |=> irq_stat_q[0] && settle_q == mux_amp_scan_pkg::ST_SETTLED)
      else $error("settle event not flagged");
   status_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `REG_IRQ_STAT && wdata_i[0] && !settle_evt |=> !irq_stat_q[0])
      else $error("settle flag not cleared");
   irq_level_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      irq_o == |(irq_stat_q & irq_mask_q))
      else $error("interrupt level wrong");
   rdata_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !rd_i |=> rdata_o == 32'h0)
      else $error("read data outside read cycle");
   chan_clamp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `REG_CHANNEL && wdata_i[5:0] > 6'h20 |=> mux_sel_o == 6'h20)
      else $error("channel not clamped to sensor");
   cal_drive_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      calmem_sda_oe_o |-> !calmem_sda_o)
      else $error("calibration data driven high");
   rear_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i != `REG_CONFIG |=> $stable(rear_connect_o))
      else $error("rear connection changed by other write");

endmodule // mux_amp_scan_control

// file: test/scan_pacer.sv
// Controller-side partner: paces scan-advance pulses for the scan control.
// Assumes one go pulse per advance and a 100 MHz clock shared with the block.
module scan_pacer #(
   parameter int GAP = 300 // 3 us at 100 MHz; lower it for a prompt partner.
) (
   // Clock.
   input wire logic clk_i,
   // Request and pulse.
   input wire logic go_i,
   output logic advance_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_q = 0;

   // The pulse comes GAP cycles after each go, so no two advances come closer.
   always @(posedge clk_i) begin
      advance_o <= (wait_q == 1);
      if (go_i) begin
         wait_q <= GAP;
      end else if (wait_q != 0) begin
         wait_q <= wait_q - 1;
      end
   end
endmodule // scan_pacer

// file: test/testbench.sv
// Self-checking bench of the scan control against a small integer model.
// Assumes the package, header, design and scan_pacer are compiled before it.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SETTLE = 20;
   localparam int GAP = 300;
   localparam logic [7:0] ID = 8'hC3; // Arbitrary identification value.
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic adv_go = 1'b0;
   logic mem_low = 1'b0;
   logic advance_i, rear_o, irq_o, cs_o, scl_o, sda_o, sda_oe, sda_i;
   logic [31:0] rdata_o, gain_o, got, g;
   logic [5:0] mux_o;
   int bad_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   int t0, n;
   int m_cfg = 0, m_gain = 0, m_chan = 0, m_mux = 0, m_irq = 0, m_cal = 0, m_mask = 0;
   bit m_set = 1'b1;

   // Open-drain data line with a pull-up; the memory may pull it low.
   assign sda_i = ~((sda_oe & ~sda_o) | mem_low);

   mux_amp_scan_control #(.IDENT_CODE(ID), .SETTLE_CYCLES(SETTLE)) uut (
      .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .advance_i(advance_i),
      .mux_sel_o(mux_o), .gain_hi_o(gain_o), .rear_connect_o(rear_o),
      .calmem_cs_o(cs_o), .calmem_scl_o(scl_o), .calmem_sda_o(sda_o),
      .calmem_sda_oe_o(sda_oe), .calmem_sda_i(sda_i), .irq_o(irq_o));
   scan_pacer #(.GAP(GAP)) pacer (.clk_i(clk_i), .go_i(adv_go), .advance_o(advance_i));

   initial forever #5 clk_i = ~clk_i;

   // A hung run is cut short well past the expected length.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         bad_count++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Model and bus tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] exp_reg(input logic [3:0] a);
      case (a)
         4'h0: return 32'(ID);
         4'h1: return 32'(m_cfg);
         4'h2: return {30'h0, m_cfg[0], m_set};
         4'h3: return 32'(m_cal) | 32'(m_cal[8] & ~mem_low);
         4'h4: return 32'(m_gain);
         4'h5: return 32'(m_chan);
         4'h6: return 32'(m_irq);
         4'h7: return 32'(m_mask);
         default: return 32'h0;
      endcase
   endfunction

   task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
      cmp_count++;
      if (gv !== ev) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, gv, ev);
      end
   endtask

   // A write also updates the model; ident, status and unmapped places ignore it.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
      case (a)
         4'h1: m_cfg = d & 3;
         4'h3: m_cal = d & 32'h700;
         4'h4: begin
            m_set = m_set && (d == m_gain);
            m_gain = d;
         end
         4'h5: begin
            m_chan = (d[5:0] > 32) ? 32 : d[5:0];
            m_mux = m_chan;
         end
         4'h6: m_irq = m_irq & ~d;
         4'h7: m_mask = d & 3;
         default: ;
      endcase
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      got = rdata_o;
   endtask

   task automatic rdc(input logic [3:0] a);
      rd(a);
      chk(got, exp_reg(a));
   endtask

   // One paced advance; the model steps through 32 channels and the sensor.
   task automatic adv();
      @(posedge clk_i);
      adv_go <= 1'b1;
      @(posedge clk_i);
      adv_go <= 1'b0;
      repeat (GAP + 2) @(posedge clk_i);
      #1;
      if (m_cfg[0] && m_mux == 32) begin
         m_mux = m_chan;
         m_irq = m_irq | 2;
      end else if (m_cfg[0]) begin
         m_mux++;
      end
      chk(mux_o, m_mux);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(3));
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      for (int a = 0; a < 16; a++) if (a != 3) rdc(4'(a));
      wr(4'h0, 32'hFFFF_FFFF);
      wr(4'h9, 32'h0000_0003);
      rdc(4'h0);
      rdc(4'h9);
      wr(4'h1, 32'h0000_0003);
      chk(rear_o, 1);
      rdc(4'h2);
      g = $urandom | 32'h1;
      wr(4'h4, g);
      t0 = cycles;
      chk(gain_o, g);
      rdc(4'h2);
      n = 0;
      while (got[0] !== 1'b1 && n < 40) begin
         rd(4'h2);
         n++;
      end
      chk(32'(cycles - t0 >= SETTLE), 1);
      m_set = 1'b1;
      m_irq = m_irq | 1;
      wr(4'h4, g);
      rdc(4'h2);
      rdc(4'h6);
      chk(irq_o, 0);
      wr(4'h7, 32'h0000_0003);
      rdc(4'h7);
      chk(irq_o, 1);
      wr(4'h6, 32'h0000_0001);
      chk(irq_o, 0);
      wr(4'h5, 32'd30);
      chk(mux_o, 30);
      repeat (3) adv();
      rdc(4'h6);
      chk(irq_o, 1);
      wr(4'h1, 32'h0000_0000);
      chk(rear_o, 0);
      adv();
      for (int i = 0; i < 4; i++) begin
         wr(4'h5, $urandom % 64);
         chk(mux_o, m_mux);
      end
      wr(4'h3, 32'h0000_0500);
      chk({cs_o, scl_o, sda_o, sda_oe}, 4'hA);
      @(posedge clk_i);
      mem_low <= 1'b1;
      repeat (3) @(posedge clk_i);
      rdc(4'h3);
      @(posedge clk_i);
      mem_low <= 1'b0;
      wr(4'h3, 32'h0000_0600);
      chk({cs_o, scl_o, sda_o, sda_oe}, 4'hD);
      rdc(4'h3);
      give_verdict();
   end
endmodule // testbench
